// ### shared/timer_unit_pkg.sv
// Package for the 8-bit timer counter unit: map, fields, modes and carriers
package timer_unit_pkg;

  // Register byte addresses, data-space view
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h43;
  localparam logic [7:0] ADDR_FLAG      = 8'h37;
  localparam logic [7:0] ADDR_POWER     = 8'h64;
  localparam logic [7:0] ADDR_MASK      = 8'h70;
  localparam logic [7:0] ADDR_CTRL_A    = 8'hb0;
  localparam logic [7:0] ADDR_CTRL_B    = 8'hb1;
  localparam logic [7:0] ADDR_COUNT     = 8'hb2;
  localparam logic [7:0] ADDR_CMP_A     = 8'hb3;
  localparam logic [7:0] ADDR_CMP_B     = 8'hb4;
  localparam logic [7:0] ADDR_ASYNC     = 8'hb6;

  // Short I/O window and extended space limits
  localparam logic [7:0] IO_SPACE_BASE  = 8'h20;
  localparam logic [7:0] IO_SPACE_LAST  = 8'h3f;
  localparam logic [7:0] EXT_SPACE_BASE = 8'h60;

  // Field positions
  localparam int SYNC_HOLD_BIT   = 7;
  localparam int ASYNC_PSR_BIT   = 1;
  localparam int SHARED_PSR_BIT  = 0;
  localparam int POWER_TIMER_BIT = 6;
  localparam int FLAG_OVF_BIT    = 0;
  localparam int FLAG_CMP_A_BIT  = 1;
  localparam int FLAG_CMP_B_BIT  = 2;
  localparam int CTRLB_WAVE2_BIT = 3;
  localparam int ASYNC_SEL_BIT   = 5;
  localparam int BUSY_COUNT_BIT  = 4;
  localparam int BUSY_CMP_A_BIT  = 3;
  localparam int BUSY_CMP_B_BIT  = 2;
  localparam int BUSY_CTRL_A_BIT = 1;
  localparam int BUSY_CTRL_B_BIT = 0;

  // Reset values, counter extremes and prescaler width
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam int         PRESCALE_W   = 10;

  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'b000,
    MODE_PHASE_MAX = 3'b001,
    MODE_CTC       = 3'b010,
    MODE_FAST_MAX  = 3'b011,
    MODE_RSVD_4    = 3'b100,
    MODE_PHASE_CMP = 3'b101,
    MODE_RSVD_6    = 3'b110,
    MODE_FAST_CMP  = 3'b111
  } wave_mode_t;

  typedef enum logic [2:0] {
    CS_STOP    = 3'b000,
    CS_DIV1    = 3'b001,
    CS_DIV8    = 3'b010,
    CS_DIV32   = 3'b011,
    CS_DIV64   = 3'b100,
    CS_DIV128  = 3'b101,
    CS_DIV256  = 3'b110,
    CS_DIV1024 = 3'b111
  } clock_select_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

  typedef enum logic [2:0] {
    TGT_NONE   = 3'b000,
    TGT_COUNT  = 3'b001,
    TGT_CMP_A  = 3'b010,
    TGT_CMP_B  = 3'b011,
    TGT_CTRL_A = 3'b100,
    TGT_CTRL_B = 3'b101
  } reg_target_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    reg_target_t target;
    logic [7:0]  data;
  } staged_write_t;

endpackage

// ### verilog/timer_counter_unit.sv
// 8-bit timer counter unit with sync control, prescaler and async oscillator tick
`timescale 1ns/1ps

module timer_counter_unit
  import timer_unit_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Processor register access
  input  wire bus_req_t   i_bus,
  output logic [7:0]      o_rdata,
  // Interrupt requests and acknowledges, bit order overflow, compare A, compare B
  input  wire logic [2:0] i_irq_ack,
  output logic [2:0]      o_irq_req,
  // Crystal oscillator pins
  input  wire logic       i_osc_pin_in,
  output logic            o_osc_pin_out,
  // Shared prescaler of the other timers
  output logic            o_shared_prescaler_reset,
  // Counter state towards waveform logic
  output logic [7:0]      o_count,
  output logic            o_timer_tick,
  output logic            o_at_bottom,
  output logic            o_at_max,
  output logic            o_match_a,
  output logic            o_match_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]    sync_ctrl;
  logic [7:0]    power_reg;
  logic [7:0]    mask_reg;
  logic [2:0]    flags;
  logic [7:0]    ctrl_a;
  logic [7:0]    ctrl_b;
  logic [7:0]    count;
  logic [7:0]    cmp_a;
  logic [7:0]    cmp_b;
  logic          async_sel;
  logic [4:0]    busy;
  count_dir_t    dir;
  logic          match_block;
  logic [PRESCALE_W-1:0] prescale;
  staged_write_t stage_1;
  staged_write_t stage_2;
  logic          osc_meta;
  logic          osc_sync;
  logic          osc_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [7:0]  eff_addr;
  logic        addr_ok;
  logic        wr_en;
  logic        rd_en;
  reg_target_t wr_target;

  always_comb begin
    eff_addr = i_bus.addr;
    addr_ok  = 1'b1;
    if (i_bus.io_space) begin
      if (i_bus.addr > IO_SPACE_LAST) begin
        addr_ok = 1'b0;
      end else begin
        eff_addr = i_bus.addr + IO_SPACE_BASE;
      end
      if (eff_addr >= EXT_SPACE_BASE) begin
        addr_ok = 1'b0;
      end
    end
  end

  assign wr_en = i_bus.wr & addr_ok;
  assign rd_en = i_bus.rd & addr_ok;

  always_comb begin
    case (eff_addr)
      ADDR_COUNT:  wr_target = TGT_COUNT;
      ADDR_CMP_A:  wr_target = TGT_CMP_A;
      ADDR_CMP_B:  wr_target = TGT_CMP_B;
      ADDR_CTRL_A: wr_target = TGT_CTRL_A;
      ADDR_CTRL_B: wr_target = TGT_CTRL_B;
      default:     wr_target = TGT_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write staging for the async clock

  staged_write_t direct_wr;
  staged_write_t apply_wr;

  always_comb begin
    direct_wr.valid  = wr_en & (wr_target != TGT_NONE);
    direct_wr.target = wr_target;
    direct_wr.data   = i_bus.wdata;
  end

  // Staged writes drain even if async select is dropped meanwhile
  always_comb begin
    if (stage_2.valid) begin
      apply_wr = stage_2;
    end else if (!async_sel) begin
      apply_wr = direct_wr;
    end else begin
      apply_wr = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage_1 <= '0;
      stage_2 <= '0;
    end else begin
      stage_1 <= async_sel ? direct_wr : '0;
      stage_2 <= stage_1;
    end
  end

  logic [4:0] busy_set;
  logic [4:0] busy_clr;

  function automatic logic [4:0] target_bit(input staged_write_t w);
    logic [4:0] b;
    b = 5'h00;
    if (w.valid) begin
      case (w.target)
        TGT_COUNT:  b[BUSY_COUNT_BIT]  = 1'b1;
        TGT_CMP_A:  b[BUSY_CMP_A_BIT]  = 1'b1;
        TGT_CMP_B:  b[BUSY_CMP_B_BIT]  = 1'b1;
        TGT_CTRL_A: b[BUSY_CTRL_A_BIT] = 1'b1;
        TGT_CTRL_B: b[BUSY_CTRL_B_BIT] = 1'b1;
        default:    b = 5'h00;
      endcase
    end
    return b;
  endfunction

  assign busy_set = async_sel ? target_bit(direct_wr) : 5'h00;
  assign busy_clr = target_bit(stage_2);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy <= 5'h00;
    end else begin
      busy <= (busy & ~busy_clr) | busy_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync control, power and async select

  logic sync_hold;
  logic async_psr;

  assign sync_hold = sync_ctrl[SYNC_HOLD_BIT];
  assign async_psr = sync_ctrl[ASYNC_PSR_BIT];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_ctrl <= RESET_BYTE;
    end else if (wr_en && eff_addr == ADDR_SYNC_CTRL) begin
      sync_ctrl                 <= RESET_BYTE;
      sync_ctrl[SYNC_HOLD_BIT]  <= i_bus.wdata[SYNC_HOLD_BIT];
      sync_ctrl[ASYNC_PSR_BIT]  <= i_bus.wdata[ASYNC_PSR_BIT];
      sync_ctrl[SHARED_PSR_BIT] <= i_bus.wdata[SHARED_PSR_BIT];
    end else if (!sync_hold) begin
      sync_ctrl[ASYNC_PSR_BIT]  <= 1'b0;
      sync_ctrl[SHARED_PSR_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_shared_prescaler_reset <= 1'b0;
    end else begin
      o_shared_prescaler_reset <= sync_ctrl[SHARED_PSR_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      power_reg <= RESET_BYTE;
      mask_reg  <= RESET_BYTE;
      async_sel <= 1'b0;
    end else if (wr_en) begin
      if (eff_addr == ADDR_POWER) begin
        power_reg <= i_bus.wdata;
      end
      if (eff_addr == ADDR_MASK) begin
        mask_reg <= i_bus.wdata;
      end
      if (eff_addr == ADDR_ASYNC) begin
        async_sel <= i_bus.wdata[ASYNC_SEL_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator pin sampling and tick generation

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_meta      <= 1'b0;
      osc_sync      <= 1'b0;
      osc_prev      <= 1'b0;
      o_osc_pin_out <= 1'b1;
    end else begin
      osc_meta      <= i_osc_pin_in;
      osc_sync      <= osc_meta;
      osc_prev      <= osc_sync;
      o_osc_pin_out <= ~osc_sync;
    end
  end

  logic          power_on;
  logic          base_tick;
  logic          timer_tick;
  logic          count_tick;
  clock_select_t clk_sel;
  wave_mode_t    mode;

  assign power_on  = power_reg[POWER_TIMER_BIT];
  assign base_tick = async_sel ? (osc_sync & ~osc_prev) : 1'b1;
  assign clk_sel   = clock_select_t'(ctrl_b[2:0]);
  assign mode      = wave_mode_t'({ctrl_b[CTRLB_WAVE2_BIT], ctrl_a[1:0]});

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prescale <= '0;
    end else if (async_psr || !power_on) begin
      prescale <= '0;
    end else if (base_tick) begin
      prescale <= prescale + 1'b1;
    end
  end

  always_comb begin
    case (clk_sel)
      CS_STOP:    timer_tick = 1'b0;
      CS_DIV1:    timer_tick = base_tick;
      CS_DIV8:    timer_tick = base_tick & (&prescale[2:0]);
      CS_DIV32:   timer_tick = base_tick & (&prescale[4:0]);
      CS_DIV64:   timer_tick = base_tick & (&prescale[5:0]);
      CS_DIV128:  timer_tick = base_tick & (&prescale[6:0]);
      CS_DIV256:  timer_tick = base_tick & (&prescale[7:0]);
      CS_DIV1024: timer_tick = base_tick & (&prescale[9:0]);
      default:    timer_tick = 1'b0;
    endcase
  end

  // Held prescaler reset halts the counter too
  assign count_tick = timer_tick & power_on & ~async_psr;

  ////////////////////////////////////////////////////////////////////////////
  // Counter unit

  logic [7:0] top;
  logic [7:0] next_count;
  count_dir_t next_dir;
  logic       ovf_event;
  logic       cnt_write;

  assign cnt_write = apply_wr.valid & (apply_wr.target == TGT_COUNT);

  always_comb begin
    case (mode)
      MODE_CTC, MODE_PHASE_CMP, MODE_FAST_CMP: top = cmp_a;
      default:                                 top = COUNT_MAX;
    endcase
  end

  always_comb begin
    next_count = count;
    next_dir   = dir;
    ovf_event  = 1'b0;
    if (cnt_write) begin
      next_count = apply_wr.data;
    end else if (count_tick) begin
      case (mode)
        MODE_NORMAL: begin
          next_count = count + 8'h01;
          ovf_event  = (count == COUNT_MAX);
          next_dir   = DIR_UP;
        end
        MODE_CTC: begin
          next_count = (count == top) ? COUNT_BOTTOM : count + 8'h01;
          ovf_event  = (count == COUNT_MAX);
          next_dir   = DIR_UP;
        end
        MODE_FAST_MAX, MODE_FAST_CMP: begin
          next_count = (count == top) ? COUNT_BOTTOM : count + 8'h01;
          ovf_event  = (count == top);
          next_dir   = DIR_UP;
        end
        MODE_PHASE_MAX, MODE_PHASE_CMP: begin
          ovf_event = (count == COUNT_BOTTOM);
          if (dir == DIR_UP) begin
            if (count >= top) begin
              next_count = count - 8'h01;
              next_dir   = DIR_DOWN;
            end else begin
              next_count = count + 8'h01;
            end
          end else begin
            if (count == COUNT_BOTTOM) begin
              next_count = count + 8'h01;
              next_dir   = DIR_UP;
            end else begin
              next_count = count - 8'h01;
            end
          end
        end
        default: begin
          next_count = count + 8'h01;
          next_dir   = DIR_UP;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count       <= RESET_BYTE;
      dir         <= DIR_UP;
      o_at_bottom <= 1'b1;
      o_at_max    <= 1'b0;
    end else begin
      count       <= next_count;
      dir         <= next_dir;
      o_at_bottom <= (next_count == COUNT_BOTTOM);
      o_at_max    <= (next_count == COUNT_MAX);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_a <= RESET_BYTE;
      ctrl_b <= RESET_BYTE;
      cmp_a  <= RESET_BYTE;
      cmp_b  <= RESET_BYTE;
    end else if (apply_wr.valid) begin
      case (apply_wr.target)
        TGT_CTRL_A: ctrl_a <= apply_wr.data;
        TGT_CTRL_B: ctrl_b <= apply_wr.data;
        TGT_CMP_A:  cmp_a  <= apply_wr.data;
        TGT_CMP_B:  cmp_b  <= apply_wr.data;
        default:    ctrl_a <= ctrl_a;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, flags and interrupt requests

  logic       match_a;
  logic       match_b;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign match_a = (count == cmp_a);
  assign match_b = (count == cmp_b);

  // A counter write masks matches on the following timer clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      match_block <= 1'b0;
    end else if (cnt_write) begin
      match_block <= 1'b1;
    end else if (count_tick) begin
      match_block <= 1'b0;
    end
  end

  always_comb begin
    flag_set                 = 3'b000;
    flag_set[FLAG_OVF_BIT]   = ovf_event;
    flag_set[FLAG_CMP_A_BIT] = count_tick & match_a & ~match_block & ~cnt_write;
    flag_set[FLAG_CMP_B_BIT] = count_tick & match_b & ~match_block & ~cnt_write;
    flag_clr                 = i_irq_ack;
    if (wr_en && eff_addr == ADDR_FLAG) begin
      flag_clr = flag_clr | i_bus.wdata[2:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags <= 3'b000;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  assign o_irq_req = flags & mask_reg[2:0];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_match_a    <= 1'b0;
      o_match_b    <= 1'b0;
      o_timer_tick <= 1'b0;
    end else begin
      o_match_a    <= match_a;
      o_match_b    <= match_b;
      o_timer_tick <= count_tick;
    end
  end

  assign o_count = count;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= RESET_BYTE;
    end else if (rd_en) begin
      case (eff_addr)
        ADDR_SYNC_CTRL: o_rdata <= sync_ctrl;
        ADDR_FLAG:      o_rdata <= {5'h00, flags};
        ADDR_POWER:     o_rdata <= power_reg;
        ADDR_MASK:      o_rdata <= mask_reg;
        ADDR_CTRL_A:    o_rdata <= ctrl_a;
        ADDR_CTRL_B:    o_rdata <= ctrl_b;
        ADDR_COUNT:     o_rdata <= count;
        ADDR_CMP_A:     o_rdata <= cmp_a;
        ADDR_CMP_B:     o_rdata <= cmp_b;
        ADDR_ASYNC:     o_rdata <= {2'b00, async_sel, busy};
        default:        o_rdata <= RESET_BYTE;
      endcase
    end
  end

endmodule // timer_counter_unit

// ### tb/timer_unit_properties.sv
// Port-level concurrent checks for the timer counter unit
`timescale 1ns/1ps

module timer_unit_properties
  import timer_unit_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Observed ports
  input  wire bus_req_t   i_bus,
  input  wire logic [7:0] o_rdata,
  input  wire logic [7:0] o_count,
  input  wire logic       o_shared_prescaler_reset,
  input  wire logic       o_timer_tick,
  input  wire logic       o_at_bottom,
  input  wire logic       o_at_max
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic sync_wr;
  logic cnt_wr;
  assign sync_wr = i_bus.wr && (i_bus.io_space ? i_bus.addr == ADDR_SYNC_CTRL - IO_SPACE_BASE
                                               : i_bus.addr == ADDR_SYNC_CTRL);
  assign cnt_wr  = i_bus.wr && !i_bus.io_space && i_bus.addr == ADDR_COUNT;

  // Track async select and recent writes; staged writes land three samples late
  logic       async_on;
  logic [2:0] wr_hist;
  logic       quiet;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      async_on <= 1'b0;
      wr_hist  <= 3'b000;
    end else begin
      wr_hist <= {wr_hist[1:0], i_bus.wr};
      if (i_bus.wr && !i_bus.io_space && i_bus.addr == ADDR_ASYNC) begin
        async_on <= i_bus.wdata[ASYNC_SEL_BIT];
      end
    end
  end
  assign quiet = !wr_hist[0] && !(async_on && (wr_hist[1] || wr_hist[2]));

  ////////////////////////////////////////////////////////////////////////////////
  chk_bottom_seen:
    assert property (o_count == COUNT_BOTTOM ##1 o_count == COUNT_BOTTOM |-> o_at_bottom)
      else $error("bottom indication missing");
  chk_max_seen:
    assert property (o_count == COUNT_MAX ##1 o_count == COUNT_MAX |-> o_at_max && !o_at_bottom)
      else $error("max indication missing");
  chk_count_step:
    assert property (quiet && !$stable(o_count) |-> o_count == COUNT_BOTTOM ||
                     o_count == 8'($past(o_count) + 8'h01) || o_count == 8'($past(o_count) - 8'h01))
      else $error("counter moved by more than one");
  chk_tick_follows:
    assert property (quiet && !$stable(o_count) |-> ##[0:1] o_timer_tick)
      else $error("count change without timer tick");
  chk_write_wins:
    assert property (cnt_wr && !async_on |=> o_count == $past(i_bus.wdata))
      else $error("counter write lost");
  chk_async_late:
    assert property (cnt_wr && async_on |-> ##3 o_count == $past(i_bus.wdata, 3))
      else $error("staged counter write lost");
  chk_read_count:
    assert property (i_bus.rd && !i_bus.io_space && i_bus.addr == ADDR_COUNT |=> o_rdata == $past(o_count))
      else $error("counter read wrong");
  chk_hold_keeps:
    assert property (sync_wr && i_bus.wdata[SYNC_HOLD_BIT] && i_bus.wdata[SHARED_PSR_BIT]
                     |-> ##2 o_shared_prescaler_reset [*3])
      else $error("prescaler reset not kept in hold mode");
  chk_hold_release:
    assert property (sync_wr && !i_bus.wdata[SYNC_HOLD_BIT] |-> ##3 !o_shared_prescaler_reset)
      else $error("prescaler reset not cleared");
  chk_short_ext_blocked:
    assert property (i_bus.wr && i_bus.io_space && i_bus.addr > IO_SPACE_LAST &&
                     i_bus.wdata != o_count |=> o_count != $past(i_bus.wdata))
      else $error("short access reached extended space");
endmodule // timer_unit_properties

// ### tb/tb_top.sv
// Self-checking testbench for the timer counter unit
`timescale 1ns/1ps

module tb_top;
  import timer_unit_pkg::*;

  logic       i_clk;
  logic       i_rst;
  bus_req_t   i_bus;
  logic [2:0] i_irq_ack;
  logic       i_osc_pin_in;
  logic [7:0] o_rdata;
  logic [7:0] o_count;
  logic [2:0] o_irq_req;
  logic       o_osc_pin_out;
  logic       o_shared_prescaler_reset;
  logic       o_timer_tick;
  logic       o_at_bottom;
  logic       o_at_max;
  logic       o_match_a;
  logic       o_match_b;
  int         bad_count;
  int         checked;
  logic [7:0] rd_val;
  logic [7:0] v;
  logic [7:0] top;
  logic [7:0] mx;
  logic [7:0] sync_tab [6] = '{8'h81, 8'h83, 8'h82, 8'h00, 8'h01, 8'h00};
  logic [7:0] ca_tab [3] = '{8'h02, 8'h03, 8'h01};
  logic [7:0] cb_tab [3] = '{8'h01, 8'h09, 8'h09};

  timer_counter_unit u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req), .i_osc_pin_in(i_osc_pin_in),
    .o_osc_pin_out(o_osc_pin_out), .o_shared_prescaler_reset(o_shared_prescaler_reset),
    .o_count(o_count), .o_timer_tick(o_timer_tick), .o_at_bottom(o_at_bottom),
    .o_at_max(o_at_max), .o_match_a(o_match_a), .o_match_b(o_match_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    i_osc_pin_in <= 1'($urandom_range(1, 0));
  end

  function automatic logic [7:0] sync_exp(input logic [7:0] w);
    return w[SYNC_HOLD_BIT] ? (w & 8'h83) : RESET_BYTE;
  endfunction

  function automatic logic ovf_exp(input wave_mode_t m);
    return m == MODE_FAST_CMP || m == MODE_FAST_MAX || m == MODE_PHASE_CMP ||
           m == MODE_PHASE_MAX;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_op(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: w, rd: !w, io_space: io, addr: a, wdata: d};
    @(posedge i_clk);
    i_bus <= '0;
    #1 rd_val = o_rdata;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    wait_cycles(5000);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    checked = 0;
    i_rst = 1'b1;
    i_bus = '0;
    i_irq_ack = 3'h0;
    i_osc_pin_in = 1'b0;
    void'($urandom(31));
    wait_cycles(10);
    check({6'h00, o_at_bottom, o_osc_pin_out}, 8'h03, "reset flags");
    check({o_at_max, o_count[6:0]}, 8'h00, "reset count");
    i_rst <= 1'b0;
    bus_op(1'b0, 1'b0, ADDR_SYNC_CTRL, 8'h00);
    check(rd_val, RESET_BYTE, "sync reset value");
    $display("test reset done");
    // Hold mode, release and self-clearing, alternating both address views
    for (int k = 0; k < 6; k++) begin
      bus_op(1'b1, 1'(k % 2), ADDR_SYNC_CTRL - (k % 2 ? IO_SPACE_BASE : 8'h00), sync_tab[k]);
      bus_op(1'b0, 1'b0, ADDR_SYNC_CTRL, 8'h00);
      check(rd_val, sync_exp(sync_tab[k]), "sync readback");
      check({7'h00, o_shared_prescaler_reset}, {7'h00, sync_exp(sync_tab[k])[0]}, "psr out");
    end
    bus_op(1'b1, 1'b1, ADDR_COUNT - IO_SPACE_BASE, 8'h5a);
    check(o_count, 8'h00, "short access above window");
    $display("test sync control done");
    for (int k = 0; k < 8; k++) begin
      v = k == 0 ? COUNT_BOTTOM : k == 1 ? COUNT_MAX : 8'($urandom);
      bus_op(1'b1, 1'b0, ADDR_COUNT, v);
      bus_op(1'b0, 1'b0, ADDR_COUNT, 8'h00);
      check(rd_val, v, "count readback");
      check({6'h00, o_at_max, o_at_bottom}, {6'h00, v == COUNT_MAX, v == COUNT_BOTTOM}, "ends");
    end
    $display("test count access done");
    bus_op(1'b1, 1'b0, ADDR_CTRL_B, 8'(CS_DIV1));
    wait_cycles(6);
    check(o_count, v, "no count while powered down");
    bus_op(1'b1, 1'b0, ADDR_CTRL_B, 8'(CS_STOP));
    bus_op(1'b1, 1'b0, ADDR_POWER, 8'h40);
    wait_cycles(6);
    check(o_count, v, "no count with clock stopped");
    bus_op(1'b1, 1'b0, ADDR_COUNT, 8'hf8);
    bus_op(1'b1, 1'b0, ADDR_FLAG, 8'h07);
    bus_op(1'b1, 1'b0, ADDR_MASK, 8'h01);
    bus_op(1'b1, 1'b0, ADDR_CTRL_B, 8'(CS_DIV1));
    for (int n = 0; n < 40 && o_irq_req[0] !== 1'b1; n++) wait_cycles(1);
    check(o_count, COUNT_BOTTOM, "overflow as count wraps");
    bus_op(1'b1, 1'b0, ADDR_CTRL_B, 8'(CS_STOP));
    bus_op(1'b1, 1'b0, ADDR_MASK, 8'h00);
    check({5'h00, o_irq_req}, 8'h00, "masked request");
    bus_op(1'b0, 1'b0, ADDR_FLAG, 8'h00);
    check(rd_val & 8'h01, 8'h01, "overflow flag kept");
    bus_op(1'b1, 1'b0, ADDR_MASK, 8'h01);
    @(posedge i_clk);
    i_irq_ack <= 3'h1;
    @(posedge i_clk);
    i_irq_ack <= 3'h0;
    wait_cycles(1);
    check({5'h00, o_irq_req}, 8'h00, "ack clears overflow");
    $display("test normal mode done");
    for (int k = 0; k < 3; k++) begin
      top = 8'($urandom_range(40, 3));
      bus_op(1'b1, 1'b0, ADDR_CTRL_A, ca_tab[k]);
      bus_op(1'b1, 1'b0, ADDR_CMP_A, top);
      bus_op(1'b1, 1'b0, ADDR_CMP_B, top - 8'h01);
      bus_op(1'b1, 1'b0, ADDR_COUNT, 8'h00);
      bus_op(1'b1, 1'b0, ADDR_FLAG, 8'h07);
      bus_op(1'b1, 1'b0, ADDR_MASK, 8'h06);
      bus_op(1'b1, 1'b0, ADDR_CTRL_B, cb_tab[k]);
      mx = 8'h00;
      repeat (3 * (top + 1)) begin
        wait_cycles(1);
        if (o_count > mx) mx = o_count;
      end
      check(mx, top, "top from compare A");
      check({5'h00, o_irq_req}, 8'h06, "compare requests");
      bus_op(1'b1, 1'b0, ADDR_COUNT, 8'h00);
      bus_op(1'b1, 1'b0, ADDR_CTRL_B, 8'(CS_STOP));
      bus_op(1'b0, 1'b0, ADDR_FLAG, 8'h00);
      check(rd_val, {5'h00, 2'b11, ovf_exp(wave_mode_t'({cb_tab[k][3], ca_tab[k][1:0]}))},
            "flags per mode");
      bus_op(1'b1, 1'b0, ADDR_FLAG, 8'h06);
      check({5'h00, o_irq_req}, 8'h00, "write one clears");
    end
    $display("test compare modes done");
    // Async select stages counter writes two cycles behind the bus
    bus_op(1'b1, 1'b0, ADDR_COUNT, 8'h00);
    bus_op(1'b1, 1'b0, ADDR_ASYNC, 8'h20);
    bus_op(1'b1, 1'b0, ADDR_COUNT, 8'h3c);
    check(o_count, 8'h00, "async write still pending");
    bus_op(1'b0, 1'b0, ADDR_ASYNC, 8'h00);
    check(rd_val, 8'h30, "async busy bit");
    check(o_count, 8'h3c, "async write applied");
    $display("test async staging done");
    give_verdict();
  end
endmodule // tb_top

bind timer_counter_unit timer_unit_properties u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .o_count(o_count),
  .o_shared_prescaler_reset(o_shared_prescaler_reset), .o_timer_tick(o_timer_tick),
  .o_at_bottom(o_at_bottom), .o_at_max(o_at_max)
);
